// *** design/pmc_pkg.sv ***
// Package with shared constants and types for the protection mode control block.
package pmc_pkg;
  localparam int unsigned CELL_COUNT = 10;
  localparam logic [7:0] MODE_STANDALONE = 8'h00;
  localparam logic [7:0] MODE_HOST = 8'h01;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_IRQ_STAT = 4'h2;
  localparam logic [3:0] REG_IRQ_MASK = 4'h3;
  localparam logic [3:0] REG_HOST_CMD = 4'h4;
  localparam logic [3:0] REG_BAL = 4'h5;
  localparam int unsigned CTRL_HOST_BIT = 0;
  localparam int unsigned CMD_CHG_BIT = 0;
  localparam int unsigned CMD_DSG_BIT = 1;
  localparam int unsigned CMD_CLR_BIT = 2;
  localparam int unsigned CMD_PRE_BIT = 3;
  localparam int unsigned CMD_AMP_BIT = 4;
  localparam int unsigned EV_OV = 0;
  localparam int unsigned EV_UV = 1;
  localparam int unsigned EV_OCD = 2;
  localparam int unsigned EV_SCD = 3;
  localparam int unsigned EV_OT = 4;
  localparam int unsigned EV_WIDTH = 5;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  typedef struct packed {
    logic cell_over;
    logic cell_under;
    logic over_temp;
    logic ov_clear;
    logic uv_clear;
    logic ot_clear;
  } pmc_sense_t;
endpackage

// *** design/pmc_link_if.sv ***
// Interface joining the protector device and the host controller.
`timescale 1ns/1ps
interface pmc_link_if;
  import pmc_pkg::*;
  logic host_mode;
  logic host_mode_wr;
  logic host_chg_on;
  logic host_dsg_on;
  logic host_fault_clear;
  logic host_precharge_on;
  logic host_amp_enable;
  logic [CELL_COUNT-1:0] host_balance;
  logic host_mode_rd;
  logic [EV_WIDTH-1:0] fault_latched;
  logic charge_fet_drive;
  logic discharge_fet_drive;
  logic alert;
  modport device (
    input host_mode, host_mode_wr, host_chg_on, host_dsg_on, host_fault_clear, host_precharge_on,
    input host_amp_enable, host_balance,
    output host_mode_rd, fault_latched, charge_fet_drive, discharge_fet_drive, alert
  );
  modport host (
    output host_mode, host_mode_wr, host_chg_on, host_dsg_on, host_fault_clear, host_precharge_on,
    output host_amp_enable, host_balance,
    input host_mode_rd, fault_latched, charge_fet_drive, discharge_fet_drive, alert
  );
endinterface

// *** design/pmc_device.sv ***
// Protector device end: mode selection, fault latching and FET, balance and precharge control.
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
// Function
// - Host-mode bit picks stand-alone or host control.
// - Stand-alone drives charge and discharge FETs itself.
// - Stand-alone balancing only when balance_enable set.
// - Stand-alone ignores host output control commands.
// - Host mode still detects faults and protects.
// - Host mode overvoltage turns charge FET off.
// - Host mode undervoltage flags only, FETs unchanged.
// - Host mode overcurrent or short turns both off.
// - Host mode leaves protection only on host command.
// - Stand-alone recovers automatically when conditions hold.
// - Host mode balancing is host's, balance_enable ignored.
// - Host stops balancing during voltage detection; cell_bypass here follows host_balance with no pause.
// - Precharge-mode high passes zero-volt charge always.
// - Precharge low, zero-volt off: no zero-volt path; precharge drive only on host command in host mode.
// - Precharge low, zero-volt on: open-drain output drives precharge.
module pmc_device (
  input wire logic sys_clk,
  input wire logic rst,
  pmc_link_if.device link,
  input wire logic balance_enable,
  input wire logic [pmc_pkg::CELL_COUNT-1:0] auto_balance_req,
  input wire logic cell_over,
  input wire logic cell_under,
  input wire logic discharge_overcurrent,
  input wire logic discharge_short_circuit,
  input wire logic over_temp,
  input wire logic ov_recovered,
  input wire logic uv_recovered,
  input wire logic oc_recovered,
  input wire logic ot_recovered,
  input wire logic precharge_mode_select,
  input wire logic zero_volt_charge_enable,
  input wire logic zero_volt_needed,
  output logic [pmc_pkg::CELL_COUNT-1:0] cell_bypass,
  output logic cell_amp_enable,
  output logic zero_volt_chg_path,
  output logic general_open_drain_out_o,
  output logic general_open_drain_out_oe_n
);
  import pmc_pkg::*;
  logic host_mode;
  logic [EV_WIDTH-1:0] fault;
  logic [EV_WIDTH-1:0] fault_now;
  logic [EV_WIDTH-1:0] recovered;
  logic [EV_WIDTH-1:0] release_ok;
  logic chg_trip_now;
  logic dsg_trip_now;
  logic chg_block_host;
  logic dsg_block_host;
  logic chg_block_auto;
  logic dsg_block_auto;
  logic chg_host;
  logic dsg_host;
  logic next_charge;
  logic next_discharge;
  logic pre_drive;
  // Overcurrent and short circuit share one recovery condition.
  assign fault_now = {over_temp, discharge_short_circuit, discharge_overcurrent, cell_under, cell_over};
  assign recovered = {ot_recovered, oc_recovered, oc_recovered, uv_recovered, ov_recovered};
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      host_mode <= 1'b0;
    end else if (link.host_mode_wr) begin
      host_mode <= link.host_mode;
    end
  end
  // Stand-alone releases a fault by itself, host mode waits for the clear command.
  always_comb begin
    release_ok = '0;
    for (int i = 0; i < EV_WIDTH; i++) begin
      if (host_mode) begin
        release_ok[i] = link.host_fault_clear && recovered[i];
      end else begin
        release_ok[i] = recovered[i];
      end
    end
  end
  // A detection in the same cycle as a release keeps the fault set.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fault <= '0;
    end else begin
      for (int i = 0; i < EV_WIDTH; i++) begin
        if (fault_now[i]) begin
          fault[i] <= 1'b1;
        end else if (release_ok[i]) begin
          fault[i] <= 1'b0;
        end
      end
    end
  end
  // Host mode leaves undervoltage and overtemperature FET action to the host.
  always_comb begin
    chg_trip_now = fault_now[EV_OV] || fault_now[EV_OCD] || fault_now[EV_SCD];
    dsg_trip_now = fault_now[EV_OCD] || fault_now[EV_SCD];
    chg_block_host = fault[EV_OV] || fault[EV_OCD] || fault[EV_SCD];
    dsg_block_host = fault[EV_OCD] || fault[EV_SCD];
    chg_block_auto = chg_block_host || fault[EV_OT];
    dsg_block_auto = dsg_block_host || fault[EV_UV] || fault[EV_OT];
  end
  // The host's charge request is dropped at once by a new overvoltage, overcurrent or short, the discharge request by overcurrent or short.
  always_ff @(posedge sys_clk) begin
    if (rst || !host_mode) begin
      chg_host <= 1'b0;
    end else begin
      chg_host <= link.host_chg_on && !chg_trip_now;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst || !host_mode) begin
      dsg_host <= 1'b0;
    end else begin
      dsg_host <= link.host_dsg_on && !dsg_trip_now;
    end
  end
  always_comb begin
    if (host_mode) begin
      next_charge = chg_host && !chg_block_host;
      next_discharge = dsg_host && !dsg_block_host;
    end else begin
      next_charge = !chg_block_auto;
      next_discharge = !dsg_block_auto;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.charge_fet_drive <= 1'b0;
    end else begin
      link.charge_fet_drive <= next_charge;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.discharge_fet_drive <= 1'b0;
    end else begin
      link.discharge_fet_drive <= next_discharge;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cell_bypass <= '0;
    end else if (host_mode) begin
      cell_bypass <= link.host_balance;
    end else if (balance_enable) begin
      cell_bypass <= auto_balance_req;
    end else begin
      cell_bypass <= '0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst || !host_mode) begin
      cell_amp_enable <= 1'b0;
    end else begin
      cell_amp_enable <= link.host_amp_enable;
    end
  end
  always_comb begin
    if (precharge_mode_select) begin
      pre_drive = 1'b0;
    end else if (host_mode) begin
      pre_drive = link.host_precharge_on;
    end else begin
      pre_drive = zero_volt_charge_enable && zero_volt_needed;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      zero_volt_chg_path <= 1'b0;
    end else begin
      zero_volt_chg_path <= precharge_mode_select;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      general_open_drain_out_oe_n <= 1'b1;
    end else begin
      general_open_drain_out_oe_n <= !pre_drive;
    end
  end
  // The open-drain pin only ever pulls low, so the enable carries the level.
  assign general_open_drain_out_o = 1'b0;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.fault_latched <= '0;
    end else begin
      link.fault_latched <= fault;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.alert <= 1'b0;
    end else begin
      link.alert <= |fault;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.host_mode_rd <= 1'b0;
    end else begin
      link.host_mode_rd <= host_mode;
    end
  end
endmodule

// *** design/pmc_host.sv ***
// Host controller end: Wishbone register file driving the device's host link.
`timescale 1ns/1ps
module pmc_host (
  input wire logic sys_clk,
  input wire logic rst,
  pmc_link_if.host link,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic irq
);
  import pmc_pkg::*;
  logic [7:0] cmd;
  logic [EV_WIDTH-1:0] irq_stat;
  logic [EV_WIDTH-1:0] irq_mask;
  logic [EV_WIDTH-1:0] fault_d;
  logic [EV_WIDTH-1:0] clr;
  logic wr;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign clr = (wr && wb_adr_i == REG_IRQ_STAT) ? wb_dat_i[EV_WIDTH-1:0] : '0;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.host_mode <= 1'b0;
      link.host_mode_wr <= 1'b0;
    end else begin
      link.host_mode_wr <= wr && wb_adr_i == REG_CTRL;
      if (wr && wb_adr_i == REG_CTRL) begin
        link.host_mode <= wb_dat_i[CTRL_HOST_BIT];
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd <= REG_RESET[7:0];
      link.host_balance <= '0;
    end else begin
      if (wr && wb_adr_i == REG_HOST_CMD) begin
        cmd <= wb_dat_i[7:0];
      end
      if (wr && wb_adr_i == REG_BAL) begin
        link.host_balance <= wb_dat_i[CELL_COUNT-1:0];
      end
    end
  end
  assign link.host_chg_on = cmd[CMD_CHG_BIT];
  assign link.host_dsg_on = cmd[CMD_DSG_BIT];
  assign link.host_fault_clear = cmd[CMD_CLR_BIT];
  assign link.host_precharge_on = cmd[CMD_PRE_BIT];
  assign link.host_amp_enable = cmd[CMD_AMP_BIT];
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fault_d <= '0;
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      fault_d <= link.fault_latched;
      irq_stat <= (irq_stat & ~clr) | (link.fault_latched & ~fault_d);
      if (wr && wb_adr_i == REG_IRQ_MASK) begin
        irq_mask <= wb_dat_i[EV_WIDTH-1:0];
      end
    end
  end
  assign irq = |(irq_stat & irq_mask);
  always_comb begin
    unique case (wb_adr_i)
      REG_CTRL: wb_dat_o = {31'h0000_0000, link.host_mode_rd};
      REG_STATUS: wb_dat_o = {24'h00_0000, link.alert, link.discharge_fet_drive, link.charge_fet_drive, link.fault_latched};
      REG_IRQ_STAT: wb_dat_o = {27'h000_0000, irq_stat};
      REG_IRQ_MASK: wb_dat_o = {27'h000_0000, irq_mask};
      REG_HOST_CMD: wb_dat_o = {24'h00_0000, cmd};
      REG_BAL: wb_dat_o = {22'h00_0000, link.host_balance};
      default: wb_dat_o = 32'h0000_0000;
    endcase
  end
endmodule

// *** verification/pmc_link_monitor.sv ***
// Checker on the link between the protector device and its host.
`timescale 1ns/1ps
module pmc_link_monitor (
  input logic sys_clk,
  input logic rst,
  input logic host_mode,
  input logic host_mode_wr,
  input logic host_chg_on,
  input logic host_dsg_on,
  input logic host_fault_clear,
  input logic host_mode_rd,
  input logic [pmc_pkg::EV_WIDTH-1:0] fault_latched,
  input logic charge_fet_drive,
  input logic discharge_fet_drive,
  input logic alert
);
  import pmc_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence host_set;
    host_mode_wr && host_mode;
  endsequence
  sequence host_idle;
    host_mode && $past(host_mode) && $past(host_mode, 2) && $past(host_mode, 3) && !host_fault_clear
      && !$past(host_fault_clear) && !$past(host_fault_clear, 2);
  endsequence
  mode_on_a: assert property (host_set |-> ##[1:3] host_mode_rd) else $error("Mode not set.");
  mode_off_a: assert property (host_mode_wr && !host_mode |-> ##[1:3] !host_mode_rd)
    else $error("Mode not cleared.");
  ov_chg_off_a: assert property (host_mode_rd && fault_latched[EV_OV] |-> ##[0:2] !charge_fet_drive)
    else $error("Charge on in overvoltage.");
  oc_both_off_a:
    assert property (host_mode_rd && (fault_latched[EV_OCD] || fault_latched[EV_SCD])
      |-> ##[0:2] !charge_fet_drive && !discharge_fet_drive) else $error("FET on in overcurrent.");
  uv_no_action_a:
    assert property (host_mode_rd && $past(host_mode_rd) && fault_latched == 5'h02 && host_chg_on && host_dsg_on
      && $past(host_chg_on, 2) && $past(host_dsg_on, 2) |-> charge_fet_drive && discharge_fet_drive)
      else $error("FET moved in undervoltage.");
  fault_hold_a: assert property (host_idle |-> (fault_latched & $past(fault_latched)) == $past(fault_latched))
    else $error("Fault left without host.");
  alert_flag_a: assert property (|fault_latched |-> ##[0:1] alert) else $error("Alert missing.");
  reset_mode_a: assert property (disable iff (1'b0) rst |=> !host_mode_rd && !alert && fault_latched == 5'h00)
    else $error("Reset state wrong.");
endmodule

// *** verification/pmc_tb.sv ***
// Testbench joining the device and host ends over their link.
`timescale 1ns/1ps
module pmc_tb;
  import pmc_pkg::*;
  logic sys_clk, rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, irq;
  logic [3:0] wb_adr_i;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic balance_enable, cell_over, cell_under, discharge_overcurrent, discharge_short_circuit, over_temp;
  logic ov_recovered, uv_recovered, oc_recovered, ot_recovered, precharge_mode_select, zero_volt_charge_enable;
  logic zero_volt_needed, cell_amp_enable, zero_volt_chg_path, general_open_drain_out_o, general_open_drain_out_oe_n;
  logic [CELL_COUNT-1:0] auto_balance_req = 10'h155;
  logic [CELL_COUNT-1:0] cell_bypass;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  pmc_link_if lnk();
  pmc_device i_pmc_device (.sys_clk, .rst, .link(lnk), .balance_enable, .auto_balance_req, .cell_over,
    .cell_under, .discharge_overcurrent, .discharge_short_circuit, .over_temp, .ov_recovered, .uv_recovered,
    .oc_recovered, .ot_recovered, .precharge_mode_select, .zero_volt_charge_enable, .zero_volt_needed,
    .cell_bypass, .cell_amp_enable, .zero_volt_chg_path, .general_open_drain_out_o, .general_open_drain_out_oe_n);
  pmc_host i_pmc_host (.sys_clk, .rst, .link(lnk), .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .irq);
  pmc_link_monitor i_pmc_link_monitor (.sys_clk, .rst, .host_mode(lnk.host_mode), .host_mode_wr(lnk.host_mode_wr),
    .host_chg_on(lnk.host_chg_on), .host_dsg_on(lnk.host_dsg_on), .host_fault_clear(lnk.host_fault_clear),
    .host_mode_rd(lnk.host_mode_rd), .fault_latched(lnk.fault_latched), .charge_fet_drive(lnk.charge_fet_drive),
    .discharge_fet_drive(lnk.discharge_fet_drive), .alert(lnk.alert));
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wt(1);
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    {rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = 40'h80_0000_0000;
    {balance_enable, cell_over, cell_under, discharge_overcurrent, discharge_short_circuit, over_temp} = 6'h00;
    {ov_recovered, uv_recovered, oc_recovered, ot_recovered, precharge_mode_select, zero_volt_charge_enable} = 6'h00;
    zero_volt_needed = 1'b1;
    wt(6);
    rst <= 1'b0;
    wt(1);
    wb(1'b0, REG_CTRL, 32'h0);
    chk("mode", rd, 32'h0);
    wb(1'b0, 4'hF, 32'h0);
    chk("unmapped", rd, 32'h0);
    wb(1'b1, REG_HOST_CMD, 32'h10);
    wt(3);
    chk("fets", {cell_amp_enable, lnk.charge_fet_drive, lnk.discharge_fet_drive}, 32'h3);
    cell_over <= 1'b1;
    wt(4);
    chk("ov", {lnk.charge_fet_drive, lnk.fault_latched}, 32'h1);
    cell_over <= 1'b0;
    ov_recovered <= 1'b1;
    wt(4);
    chk("recover", {lnk.charge_fet_drive, lnk.fault_latched}, 32'h20);
    balance_enable <= 1'b1;
    wt(3);
    chk("bal_on", cell_bypass, 32'h155);
    balance_enable <= 1'b0;
    wt(3);
    chk("bal_off", cell_bypass, 32'h0);
    for (int k = 0; k < 3; k++) begin
      {precharge_mode_select, zero_volt_charge_enable} <= 2'(k);
      wt(3);
      chk("precharge", {zero_volt_chg_path, general_open_drain_out_oe_n, general_open_drain_out_o},
        {k == 2, k != 1, 1'b0});
    end
    wb(1'b1, REG_CTRL, 32'h1);
    wt(3);
    wb(1'b0, REG_CTRL, 32'h0);
    chk("host_mode", rd, 32'h1);
    wb(1'b1, REG_IRQ_STAT, 32'h1F);
    wb(1'b1, REG_HOST_CMD, 32'h3);
    balance_enable <= 1'b1;
    wb(1'b1, REG_BAL, 32'h2A5);
    wt(3);
    chk("host_bal", cell_bypass, 32'h2A5);
    balance_enable <= 1'b0;
    wb(1'b1, REG_HOST_CMD, 32'h1B);
    wt(3);
    chk("host_pre_on", {cell_amp_enable, zero_volt_chg_path, general_open_drain_out_oe_n}, 32'h7);
    precharge_mode_select <= 1'b0;
    wt(3);
    chk("host_pre", {cell_amp_enable, zero_volt_chg_path, general_open_drain_out_oe_n}, 32'h4);
    wb(1'b1, REG_HOST_CMD, 32'h3);
    wb(1'b1, REG_BAL, 32'h0);
    cell_over <= 1'b1;
    wt(4);
    chk("host_ov", {lnk.charge_fet_drive, lnk.discharge_fet_drive}, 32'h1);
    cell_over <= 1'b0;
    wt(6);
    chk("host_hold", {lnk.charge_fet_drive, lnk.fault_latched}, 32'h1);
    wb(1'b1, REG_HOST_CMD, 32'h7);
    wb(1'b1, REG_HOST_CMD, 32'h3);
    wt(3);
    chk("host_clear", {lnk.charge_fet_drive, lnk.fault_latched}, 32'h20);
    cell_under <= 1'b1;
    wt(4);
    chk("host_uv", {lnk.charge_fet_drive, lnk.discharge_fet_drive, lnk.fault_latched}, 32'h62);
    cell_under <= 1'b0;
    uv_recovered <= 1'b1;
    wb(1'b1, REG_HOST_CMD, 32'h7);
    wb(1'b1, REG_HOST_CMD, 32'h3);
    discharge_overcurrent <= 1'b1;
    discharge_short_circuit <= 1'b1;
    wt(4);
    chk("host_oc", {lnk.charge_fet_drive, lnk.discharge_fet_drive, lnk.alert}, 32'h1);
    wb(1'b0, REG_IRQ_STAT, 32'h0);
    chk("irq_stat", rd & 32'h0C, 32'h0C);
    wb(1'b1, REG_IRQ_MASK, 32'h0);
    chk("irq_masked", irq, 32'h0);
    wb(1'b1, REG_IRQ_MASK, 32'h1F);
    chk("irq_mask", irq, 32'h1);
    discharge_overcurrent <= 1'b0;
    discharge_short_circuit <= 1'b0;
    oc_recovered <= 1'b1;
    wb(1'b1, REG_HOST_CMD, 32'h7);
    wb(1'b1, REG_HOST_CMD, 32'h3);
    wt(3);
    chk("oc_clear", {lnk.charge_fet_drive, lnk.discharge_fet_drive, lnk.fault_latched}, 32'h60);
    over_temp <= 1'b1;
    wt(4);
    over_temp <= 1'b0;
    ot_recovered <= 1'b1;
    wt(4);
    chk("host_ot", {lnk.charge_fet_drive, lnk.discharge_fet_drive, lnk.fault_latched}, 32'h70);
    wb(1'b1, REG_HOST_CMD, 32'h7);
    wb(1'b1, REG_HOST_CMD, 32'h3);
    wt(3);
    chk("ot_clear", {lnk.charge_fet_drive, lnk.discharge_fet_drive, lnk.fault_latched}, 32'h60);
    wb(1'b1, REG_IRQ_STAT, 32'h1F);
    wb(1'b0, REG_IRQ_STAT, 32'h0);
    chk("irq_clear", {irq, rd[4:0]}, 32'h0);
    rst <= 1'b1;
    wt(2);
    rst <= 1'b0;
    wt(1);
    wb(1'b0, REG_CTRL, 32'h0);
    chk("reset_mode", rd, 32'h0);
    wb(1'b0, REG_HOST_CMD, 32'h0);
    chk("reset_cmd", rd, 32'h0);
    wb(1'b1, REG_CTRL, 32'h0);
    wt(3);
    chk("standalone", lnk.host_mode_rd, 32'h0);
    test_done();
  end
endmodule
